// >>> shared/slsd_pkg.sv
// Package: shared constants and types of the serial latched sink driver
`default_nettype none
package slsd_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;  // Core clock rate
  localparam int unsigned NUM_SINKS     = 8;           // Stages/latches/sinks
  localparam int unsigned FIFO_WIDTH    = 8;           // Pattern word width
  localparam int unsigned FIFO_DEPTH    = 32;          // Pattern words
  localparam int unsigned FIFO_AW       = 5;           // FIFO address bits
  // Host timing, printed figures in their own units
  localparam int unsigned GAP_NS        = 100;   // Shift-to-strobe gap
  localparam int unsigned STROBE_NS     = 100;   // Strobe high width
  localparam int unsigned BLANK_NS      = 4500;  // Least blanking pulse
  localparam int unsigned SHIFT_MAX_HZ  = 10_000_000; // Max shift clock rate
  // Derived cycle counts (least times round up)
  localparam int unsigned GAP_CYC    = (GAP_NS * (CLK_HZ / 1_000_000) + 999)
                                       / 1000;
  localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999)
                                       / 1000;
  localparam int unsigned BLANK_CYC  = (BLANK_NS * (CLK_HZ / 1_000_000) + 999)
                                       / 1000;
  // Half period of the shift clock, rounded up so the rate stays at or below max
  localparam int unsigned HALF_CYC   = (CLK_HZ + 2 * SHIFT_MAX_HZ - 1)
                                       / (2 * SHIFT_MAX_HZ);
  localparam logic [7:0]  CNT_ZERO   = 8'h00;  // Counter reset value
  localparam logic [7:0]  PAT_RESET  = 8'h00;  // Latch and stage reset value
  typedef enum {SLSD_IDLE, SLSD_BLANK, SLSD_LOW, SLSD_HIGH, SLSD_GAP,
                SLSD_STROBE, SLSD_HOLD} slsd_state_t;
endpackage : slsd_pkg
`default_nettype wire

// >>> shared/slsd_if.sv
// Interface: the four host lines and the cascade line between both ends
`timescale 1ns/1ps
`default_nettype none
interface slsd_if;
  logic serial_in;    // Serial data, host to device
  logic shift_clk;    // Shift clock, host to device
  logic strobe;       // Latch strobe, high = transparent
  logic blank;        // Blanking, high = all sinks off
  logic cascade_out;  // Bit shifted out of last stage
  modport device (input serial_in, shift_clk, strobe, blank,
                  output cascade_out);
  modport host (output serial_in, shift_clk, strobe, blank,
                input cascade_out);
endinterface : slsd_if
`default_nettype wire

// >>> hdl/slsd_device.sv
// Device end: shift register, latches and blankable sink outputs
// What this block does
// - Rising shift edge captures serial input
// - Later edges move bits toward cascade
// - Host sets data before rising edge
// - Strobe high copies stages into latches
// - Latches stay transparent while strobe high
// - Strobe tied high needs blank high
// - Blank high turns all sinks off
// - Blanking never alters latch contents
// - Blank low: sinks follow their latches
// - Eight stages, latches, sinks, numbered 0-7
// - Cascade output shows last stage bit
// - Host waits 100 ns before strobe
// - Strobe pulse high at least 100 ns
// - Blank pulses last at least 4.5 us
// - Shift clock at most 10 MHz
`timescale 1ns/1ps
`default_nettype none
module slsd_device (
  input  wire logic       clk_i,          // 50 MHz core clock
  input  wire logic       resetn_i,       // Async reset, active low
  slsd_if.device          link,           // Host lines
  output var  logic [7:0] sink_outputs_o, // 1 = sink on
  output var  logic [7:0] latch_view_o    // Latch contents
);
  // Two-flop synchronisers for all pin inputs
  logic [3:0] meta_reg;                   // First stage, read by sync only
  logic [3:0] sync_reg;                   // Second stage
  logic       clk_prev_reg;               // Shift clock history
  logic [7:0] stage_reg;                  // Shift stages 0..7
  logic [7:0] latch_reg;                  // Latches 0..7
  wire        data_s   = sync_reg[0];     // Synchronised serial in
  wire        sclk_s   = sync_reg[1];     // Synchronised shift clock
  wire        strobe_s = sync_reg[2];     // Synchronised strobe
  wire        blank_s  = sync_reg[3];     // Synchronised blank
  wire        rise     = sclk_s & ~clk_prev_reg; // Shift clock rising edge
  wire [7:0]  stage_next = {stage_reg[6:0], data_s};
  // Transparent latch modelled in the core clock: follows newest stages
  wire [7:0]  latch_next = strobe_s ? (rise ? stage_next : stage_reg)
                                    : latch_reg;

  // Synchronise pins; the first flop feeds only the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end else begin
      meta_reg <= {link.blank, link.strobe, link.shift_clk, link.serial_in};
      sync_reg <= meta_reg;
    end
  end

  // Shift on each detected rising edge; stage 7 is the oldest bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_prev_reg <= 1'b0;
      stage_reg    <= slsd_pkg::PAT_RESET;
    end else begin
      clk_prev_reg <= sclk_s;
      if (rise) begin
        stage_reg <= stage_next;
      end
    end
  end

  // Latches; blank is not an input here so it cannot disturb them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_reg <= slsd_pkg::PAT_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Registered outputs; blank gates sinks, latch one means on
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sink_outputs_o   <= slsd_pkg::PAT_RESET;
      latch_view_o     <= slsd_pkg::PAT_RESET;
      link.cascade_out <= 1'b0;
    end else begin
      sink_outputs_o   <= blank_s ? 8'h00
                                  : latch_next;
      latch_view_o     <= latch_next;
      link.cascade_out <= rise ? stage_next[7] : stage_reg[7];
    end
  end
endmodule : slsd_device
`default_nettype wire

// >>> hdl/slsd_host.sv
// Host end: pattern FIFO and a sequencer that shifts, strobes and blanks
`timescale 1ns/1ps
`default_nettype none
module slsd_fifo #(
  parameter int unsigned WIDTH = 8,       // Word width
  parameter int unsigned DEPTH = 32,      // Words
  parameter int unsigned AW    = 5        // Address bits
) (
  input  wire logic             clk_i,    // Core clock
  input  wire logic             resetn_i, // Async reset, active low
  input  wire logic             in_valid_i, // Write offered
  output var  logic             in_ready_o, // Not full
  input  wire logic [WIDTH-1:0] in_data_i,  // Write word
  output var  logic             out_valid_o, // Not empty
  input  wire logic             out_ready_i, // Read taken
  output var  logic [WIDTH-1:0] out_data_o   // Head word
);
  logic [WIDTH-1:0] mem [DEPTH];          // Storage
  logic [AW:0]      wr_reg;               // Write pointer with wrap bit
  logic [AW:0]      rd_reg;               // Read pointer with wrap bit
  // Same slot, other lap: every slot holds an unread word
  wire  full  = (wr_reg[AW] != rd_reg[AW]) &&
                (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire  empty = (wr_reg == rd_reg);
  wire  push  = in_valid_i & ~full;
  wire  pop   = out_ready_i & ~empty;
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[rd_reg[AW-1:0]];

  // Storage write, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : slsd_fifo

module slsd_host (
  input  wire logic       clk_i,          // 50 MHz core clock
  input  wire logic       resetn_i,       // Async reset, active low
  slsd_if.host            link,           // Lines to the device
  input  wire logic       pat_valid_i,    // Pattern word offered
  output var  logic       pat_ready_o,    // FIFO has room
  input  wire logic [7:0] pat_data_i,     // Pattern, bit 7 shifted first
  input  wire logic       blank_req_i,    // Level: request blanking
  output var  logic       busy_o,         // Sequencer active
  output var  logic       cascade_o       // Synchronised cascade bit
);
  slsd_pkg::slsd_state_t state_reg, state_next; // Sequencer state
  logic [7:0] cnt_reg, cnt_next;          // Cycle counter
  logic [2:0] bit_reg, bit_next;          // Bits left minus one
  logic [7:0] word_reg, word_next;        // Word being shifted
  logic       fifo_valid;                 // FIFO head valid
  logic       fifo_ready;                 // FIFO pop
  logic       fifo_in_ready;              // FIFO room
  logic [7:0] fifo_data;                  // FIFO head
  logic       casc_meta_reg, casc_sync_reg; // Cascade synchroniser
  logic       blank_reg;                  // Blank line register
  logic [7:0] blank_cnt_reg;              // Blank pulse width counter
  wire  [7:0] half_c   = 8'(slsd_pkg::HALF_CYC - 1);
  wire  [7:0] gap_c    = 8'(slsd_pkg::GAP_CYC - 1);
  wire  [7:0] strobe_c = 8'(slsd_pkg::STROBE_CYC - 1);
  wire        cnt_done = (cnt_reg == slsd_pkg::CNT_ZERO);

  // Words wait here; a stalled sequencer fills it and back-pressures source
  slsd_fifo #(.WIDTH(slsd_pkg::FIFO_WIDTH), .DEPTH(slsd_pkg::FIFO_DEPTH),
              .AW(slsd_pkg::FIFO_AW)) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (pat_valid_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pat_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );
  assign fifo_ready = (state_reg == slsd_pkg::SLSD_IDLE);

  // Sequencer: data set a half period before each rising edge
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - 8'h01;
    bit_next   = bit_reg;
    word_next  = word_reg;
    case (state_reg)
      slsd_pkg::SLSD_IDLE: begin
        if (fifo_valid) begin
          word_next  = fifo_data;
          bit_next   = 3'h7;
          cnt_next   = half_c;
          state_next = slsd_pkg::SLSD_LOW;
        end
      end
      slsd_pkg::SLSD_LOW: begin
        if (cnt_done) begin
          cnt_next   = half_c;
          state_next = slsd_pkg::SLSD_HIGH;
        end
      end
      slsd_pkg::SLSD_HIGH: begin
        if (cnt_done) begin
          cnt_next  = half_c;
          word_next = {word_reg[6:0], 1'b0};
          if (bit_reg == 3'h0) begin
            cnt_next   = gap_c;
            state_next = slsd_pkg::SLSD_GAP;
          end else begin
            bit_next   = bit_reg - 3'h1;
            state_next = slsd_pkg::SLSD_LOW;
          end
        end
      end
      slsd_pkg::SLSD_GAP: begin
        if (cnt_done) begin
          cnt_next   = strobe_c;
          state_next = slsd_pkg::SLSD_STROBE;
        end
      end
      slsd_pkg::SLSD_STROBE: begin
        if (cnt_done) begin
          state_next = slsd_pkg::SLSD_IDLE;
        end
      end
      default: state_next = slsd_pkg::SLSD_IDLE;
    endcase
  end

  // Sequencer registers and the driven lines
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg      <= slsd_pkg::SLSD_IDLE;
      cnt_reg        <= slsd_pkg::CNT_ZERO;
      bit_reg        <= 3'h0;
      word_reg       <= slsd_pkg::PAT_RESET;
      link.serial_in <= 1'b0;
      link.shift_clk <= 1'b0;
      link.strobe    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      bit_reg        <= bit_next;
      word_reg       <= word_next;
      link.serial_in <= word_next[7];
      link.shift_clk <= (state_next == slsd_pkg::SLSD_HIGH);
      link.strobe    <= (state_next == slsd_pkg::SLSD_STROBE);
    end
  end

  // Blank follows request but every pulse lasts the least width
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blank_reg     <= 1'b1;              // Blanked until the first cycle with request low
      blank_cnt_reg <= slsd_pkg::CNT_ZERO;
    end else if (blank_cnt_reg != slsd_pkg::CNT_ZERO) begin
      blank_cnt_reg <= blank_cnt_reg - 8'h01;
    end else if (blank_req_i != blank_reg) begin
      blank_reg     <= blank_req_i;
      blank_cnt_reg <= 8'(slsd_pkg::BLANK_CYC - 1);
    end
  end
  always_comb link.blank = blank_reg;

  // Cascade synchroniser and status outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      casc_meta_reg <= 1'b0;
      casc_sync_reg <= 1'b0;
      cascade_o     <= 1'b0;
      busy_o        <= 1'b0;
      pat_ready_o   <= 1'b0;
    end else begin
      casc_meta_reg <= link.cascade_out;
      casc_sync_reg <= casc_meta_reg;
      cascade_o     <= casc_sync_reg;
      busy_o        <= (state_next != slsd_pkg::SLSD_IDLE);
      pat_ready_o   <= fifo_in_ready;
    end
  end
endmodule : slsd_host
`default_nettype wire

// >>> verification/slsd_checker.sv
// Checker: timing and output relations seen on the host-device link
`timescale 1ns/1ps
`default_nettype none
module slsd_checker (
  input wire logic       clk_i,          // Core clock
  input wire logic       resetn_i,       // Async reset, active low
  input wire logic       serial_in,      // Serial data
  input wire logic       shift_clk,      // Shift clock
  input wire logic       strobe,         // Latch strobe
  input wire logic       blank,          // Blanking
  input wire logic       cascade_out,    // Cascade bit
  input wire logic [7:0] sink_outputs_o, // Sinks, 1 = on
  input wire logic [7:0] latch_view_o    // Latch contents
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [3:0] since_rise; // Cycles since last shift clock rise
  logic [8:0] run_cnt;    // Cycles blank has held its level
  // Saturating counters; blank run starts full, reset is not a pulse
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_rise <= 4'hf;
      run_cnt    <= 9'h1ff;
    end else begin
      since_rise <= $rose(shift_clk) ? 4'h0 :
                    (since_rise == 4'hf ? since_rise : since_rise + 4'h1);
      run_cnt    <= $changed(blank) ? 9'h000 :
                    (run_cnt == 9'h1ff ? run_cnt : run_cnt + 9'h001);
    end
  end
  a_data_setup: assert property (shift_clk |-> $stable(serial_in))
    else $error("serial data moved while shift clock high");
  a_strobe_gap: assert property
    ($rose(strobe) |-> since_rise >= 4'h4)
    else $error("strobe raised too soon after a shift edge");
  a_strobe_width: assert property ($rose(strobe) |-> strobe [*5])
    else $error("strobe pulse shorter than five cycles");
  a_blank_width: assert property
    ($changed(blank) |-> run_cnt >= 9'h0e0)
    else $error("blank level held too briefly");
  a_shift_rate: assert property
    ($rose(shift_clk) |-> shift_clk [*3] ##1 !shift_clk [*3])
    else $error("shift clock phase too short");
  a_blank_sinks_off: assert property
    (blank [*6] |-> sink_outputs_o == 8'h00)
    else $error("sinks on while blanked");
  a_sinks_follow: assert property
    ((!blank && $stable(latch_view_o)) [*6] |-> sink_outputs_o == latch_view_o)
    else $error("sinks differ from latches while unblanked");
  a_latch_hold: assert property
    (!strobe [*6] |-> $stable(latch_view_o))
    else $error("latches changed with strobe low");
  // Device sees blank three cycles late, so watch five cycles after it
  a_blank_keeps: assert property
    ((!strobe [*6] ##1 ($changed(blank) && !strobe))
     |=> $stable(latch_view_o) [*5])
    else $error("blanking altered the latches");
  a_cascade_still: assert property
    (!shift_clk [*6] |-> $stable(cascade_out))
    else $error("cascade moved without a shift edge");
  c_frame: cover property ($rose(strobe));
  c_blank_on: cover property ($rose(blank));
  c_blank_off: cover property ($fell(blank));
endmodule : slsd_checker
`default_nettype wire

// >>> verification/tb_serial_latched_sink_driver.sv
// Testbench: host drives one device; the bench drives a second device
`timescale 1ns/1ps
`default_nettype none
module tb_serial_latched_sink_driver;
  logic       clk_i     = 1'b0;  // Core clock
  logic       resetn_i  = 1'b0;  // Reset, active low
  logic       pat_valid = 1'b0;  // Word offered
  logic [7:0] pat_data  = 8'h00; // Offered word
  logic       blank_req = 1'b0;  // Host blanking request
  logic       exp_blank = 1'b0;  // Model of host blanking
  logic       refused   = 1'b0;  // FIFO refused at least once
  logic       pat_ready, busy, cascade;
  logic [7:0] sink, latch, sink2, latch2, fw, mw;
  logic [7:0] q[$];              // Words awaiting their frame
  logic [31:0] lfsr = 32'h7079_e2a7; // Random source
  int         sr2 = 0;           // Model of second device stages
  int         err_total = 0;     // Mismatches
  int         total_checks = 0;  // Comparisons
  slsd_if lk ();
  slsd_if lk2 ();
  slsd_host slsd_host_i (.clk_i(clk_i), .resetn_i(resetn_i), .link(lk.host),
    .pat_valid_i(pat_valid), .pat_ready_o(pat_ready), .pat_data_i(pat_data),
    .blank_req_i(blank_req), .busy_o(busy), .cascade_o(cascade));
  slsd_device slsd_device_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(lk.device), .sink_outputs_o(sink), .latch_view_o(latch));
  slsd_device slsd_device_x_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(lk2.device), .sink_outputs_o(sink2), .latch_view_o(latch2));
  slsd_checker slsd_checker_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .serial_in(lk.serial_in), .shift_clk(lk.shift_clk), .strobe(lk.strobe),
    .blank(lk.blank), .cascade_out(lk.cascade_out),
    .sink_outputs_o(sink), .latch_view_o(latch));
  // Free-running core clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Offer a word until taken; one idle cycle lets the ready flag catch up
  task automatic push(input logic [7:0] w);
    int n;
    n = 0;
    pat_data  = w;
    pat_valid = 1'b1;
    if (!pat_ready) refused = 1'b1;
    while (!pat_ready && n < 4000) begin
      n++;
      @(negedge clk_i);
    end
    if (n == 4000) begin
      err_total++;
      tally_and_finish();
    end
    @(negedge clk_i);
    pat_valid = 1'b0;
    q.push_back(w);
    @(negedge clk_i);
  endtask : push
  // Bounded wait until every queued frame was checked
  task automatic drain();
    int n;
    n = 0;
    while ((q.size() != 0 || busy) && n < 8000) begin
      n++;
      @(negedge clk_i);
    end
    if (n == 8000) begin
      err_total++;
      tally_and_finish();
    end
    repeat (12) @(negedge clk_i);
  endtask : drain
  // One frame on the second link, 160 ns clock, still outside frames
  task automatic shift2(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      lk2.serial_in = b[i]; // Data set a half period ahead
      #80 lk2.shift_clk = 1'b1; // 6.25 MHz, below the limit
      #80 lk2.shift_clk = 1'b0;
      sr2 = ((sr2 << 1) | b[i]) & 255;
    end
    lk2.serial_in = ~lk2.serial_in; // Released line shows no stale level
  endtask : shift2
  // Per finished frame: latches, sinks and cascade against the model
  always @(negedge lk.strobe) begin
    if (resetn_i) begin
      repeat (8) @(negedge clk_i);
      fw = q.size() != 0 ? q.pop_front() : 8'hxx;
      check("latch", latch, fw);
      check("sink", sink, exp_blank ? 8'h00 : fw);
      check("cascade", {7'h00, cascade}, {7'h00, fw[7]});
      // Sequencer stays busy while frames remain in the model queue
      check("busy", {7'h00, busy}, {7'h00, q.size() != 0});
    end
  end
  // Main sequence
  initial begin
    lk2.serial_in = 1'b0;
    lk2.shift_clk = 1'b0;
    lk2.strobe    = 1'b0;
    lk2.blank     = 1'b1;
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (300) @(negedge clk_i); // Host lifts blank at once, then waits out its hold
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsr_next(lfsr);
      push(lfsr[7:0]);
    end
    check("refused", {7'h00, refused}, 8'h01); // FIFO filled
    drain();
    exp_blank = 1'b1;
    blank_req = 1'b1;
    repeat (300) @(negedge clk_i);
    push(8'hff);
    drain();
    exp_blank = 1'b0;
    blank_req = 1'b0;
    repeat (300) @(negedge clk_i);
    push(8'h01);
    push(8'h80);
    drain();
    // Second device: strobe held high needs blank high
    lk2.strobe = 1'b1;
    for (int k = 0; k < 2; k++) begin
      lfsr = lfsr_next(lfsr);
      shift2(lfsr[7:0]);
      #200;
      check("transparent", latch2, 8'(sr2));
      check("blanked", sink2, 8'h00);
      check("cascade2", {7'h00, lk2.cascade_out}, {7'h00, sr2[7]});
    end
    lk2.strobe = 1'b0;
    #200;
    mw = sr2[7:0];
    shift2(8'h5a);
    #200;
    check("held", latch2, mw);
    lk2.blank = 1'b0; // Blank levels held 4.6 us
    #4600;
    check("driven", sink2, mw);
    lk2.blank = 1'b1;
    #4600;
    lk2.blank = 1'b0;
    #4600;
    check("kept", latch2, mw);
    lk2.strobe = 1'b1; // Width of 200 ns, then 200 ns before checks
    #200;
    lk2.strobe = 1'b0;
    #200;
    check("strobed", latch2, 8'(sr2));
    check("sinks2", sink2, 8'(sr2));
    tally_and_finish();
  end
endmodule : tb_serial_latched_sink_driver
`default_nettype wire
